// ---- verilog/imfb_regs.svh ----
// Register indices, field positions and reset values of the mask and flag bank
`ifndef IMFB_REGS_SVH
`define IMFB_REGS_SVH

`define IMFB_ADDR_W 18
`define IMFB_IDX_W 16
`define IMFB_WORD_W 4

`define IMFB_IDX_PWM_SEL 16'hFFD8
`define IMFB_IDX_MATCH_EN 16'hFFE0
`define IMFB_IDX_WRAP_EN 16'hFFE1
`define IMFB_IDX_KEYS_A_EN 16'hFFE3
`define IMFB_IDX_KEYS_B_EN 16'hFFE4
`define IMFB_IDX_TICK_EN 16'hFFE5
`define IMFB_IDX_CONV_EN 16'hFFE7
`define IMFB_IDX_MATCH_EV 16'hFFF0
`define IMFB_IDX_WRAP_EV 16'hFFF1
`define IMFB_IDX_KEYS_A_EV 16'hFFF3
`define IMFB_IDX_KEYS_B_EV 16'hFFF4
`define IMFB_IDX_TICK_EV 16'hFFF5
`define IMFB_IDX_CONV_EV 16'hFFF7

`define IMFB_BIT_T0 0
`define IMFB_BIT_T1 1
`define IMFB_BIT_KEYS 0
`define IMFB_BIT_TICK32 0
`define IMFB_BIT_TICK8 1
`define IMFB_BIT_TICK2 2
`define IMFB_BIT_TICK1 3
`define IMFB_BIT_SENSOR 0
`define IMFB_BIT_REF 1

`define IMFB_RST_2 2'h0
`define IMFB_RST_1 1'h0
`define IMFB_RST_4 4'h0

`endif

// ---- verilog/imfb_pkg.sv ----
// Types shared by the mask and flag bank
package imfb_pkg;
   typedef enum logic [1:0] {
      IMFB_RESP_OKAY = 2'b00,
      IMFB_RESP_SLVERR = 2'b10
   } imfb_resp_t;
endpackage

// ---- verilog/imfb_event_word.sv ----
// Sticky event flags with write-one-to-clear, set winning over clear
`timescale 1ns/1ps
module imfb_event_word #(
   parameter int W = 2
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [W-1:0] set_in,
   input wire logic [W-1:0] clr_in,
   output logic [W-1:0] flag
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic flag_r;
         logic flag_nxt;
         // Event in the clearing cycle is kept
         assign flag_nxt = set_in[i] | (flag_r & ~clr_in[i]);
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               flag_r <= 1'b0;
            end else begin
               flag_r <= flag_nxt;
            end
         end
         assign flag[i] = flag_r;
      end
   endgenerate
endmodule

// ---- verilog/imfb_axil_slave.sv ----
// AXI4-Lite slave front end: one write and one read in flight
`timescale 1ns/1ps
module imfb_axil_slave #(
   parameter int AW = 18
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [AW-1:0] wr_addr,
   output logic [3:0] wr_data,
   input wire logic wr_hit,
   output logic [AW-1:0] rd_addr,
   input wire logic [3:0] rd_data,
   input wire logic rd_hit
);
   logic aw_have_r;
   logic w_have_r;
   logic [AW-1:0] aw_addr_r;
   logic [3:0] w_data_r;
   logic w_strb0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;
   logic wr_fire;
   logic ar_fire;

   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready = ~w_have_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;
   assign ar_fire = s_axi_arvalid & ~rvalid_r;
   // Only byte lane 0 carries register bits
   assign wr_en = wr_fire & w_strb0_r;
   assign wr_addr = aw_addr_r;
   assign wr_data = w_data_r;
   assign rd_addr = s_axi_araddr;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= 4'h0;
         w_strb0_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata[3:0];
            w_strb0_r <= s_axi_wstrb[0];
         end else if (wr_fire) begin
            w_have_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= 2'b00;
      end else if (wr_fire) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_hit ? imfb_pkg::IMFB_RESP_OKAY : imfb_pkg::IMFB_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rresp_r <= 2'b00;
         rdata_r <= 32'h0000_0000;
      end else if (ar_fire) begin
         rvalid_r <= 1'b1;
         rresp_r <= rd_hit ? imfb_pkg::IMFB_RESP_OKAY : imfb_pkg::IMFB_RESP_SLVERR;
         rdata_r <= {28'h000_0000, rd_data};
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end
endmodule

// ---- verilog/imfb_irq_bank.sv ----
// Interrupt enable masks, event flags and PWM route bits behind AXI4-Lite
`timescale 1ns/1ps
`include "imfb_regs.svh"
module imfb_irq_bank (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [`IMFB_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`IMFB_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] timer_match_event,
   input wire logic [1:0] timer_wrap_event,
   input wire logic keys_a_event,
   input wire logic keys_b_event,
   input wire logic [3:0] tick_event,
   input wire logic [1:0] conv_event,
   output logic timer0_pwm_route,
   output logic timer1_pwm_route,
   output logic irq_req
);
   logic wr_en;
   logic [`IMFB_ADDR_W-1:0] wr_addr;
   logic [3:0] wr_data;
   logic wr_hit;
   logic [`IMFB_ADDR_W-1:0] rd_addr;
   logic [3:0] rd_data;
   logic rd_hit;

   // Protection bits carry no meaning here
   logic prot_unused;
   assign prot_unused = ^{s_axi_awprot, s_axi_arprot};

   imfb_axil_slave #(
      .AW(`IMFB_ADDR_W)
   ) u_bus (
      .clock(clock),
      .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_hit(wr_hit),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_hit(rd_hit)
   );

   // Word index decode; byte address is four times the index
   logic [`IMFB_IDX_W-1:0] wr_idx;
   logic [`IMFB_IDX_W-1:0] rd_idx;
   logic wr_aligned;
   logic rd_aligned;
   assign wr_idx = wr_addr[`IMFB_ADDR_W-1:2];
   assign rd_idx = rd_addr[`IMFB_ADDR_W-1:2];
   assign wr_aligned = (wr_addr[1:0] == 2'h0);
   assign rd_aligned = (rd_addr[1:0] == 2'h0);

   logic w_pwm;
   logic w_match_en;
   logic w_wrap_en;
   logic w_keys_a_en;
   logic w_keys_b_en;
   logic w_tick_en;
   logic w_conv_en;
   logic w_match_ev;
   logic w_wrap_ev;
   logic w_keys_a_ev;
   logic w_keys_b_ev;
   logic w_tick_ev;
   logic w_conv_ev;
   assign w_pwm = wr_aligned & (wr_idx == `IMFB_IDX_PWM_SEL);
   assign w_match_en = wr_aligned & (wr_idx == `IMFB_IDX_MATCH_EN);
   assign w_wrap_en = wr_aligned & (wr_idx == `IMFB_IDX_WRAP_EN);
   assign w_keys_a_en = wr_aligned & (wr_idx == `IMFB_IDX_KEYS_A_EN);
   assign w_keys_b_en = wr_aligned & (wr_idx == `IMFB_IDX_KEYS_B_EN);
   assign w_tick_en = wr_aligned & (wr_idx == `IMFB_IDX_TICK_EN);
   assign w_conv_en = wr_aligned & (wr_idx == `IMFB_IDX_CONV_EN);
   assign w_match_ev = wr_aligned & (wr_idx == `IMFB_IDX_MATCH_EV);
   assign w_wrap_ev = wr_aligned & (wr_idx == `IMFB_IDX_WRAP_EV);
   assign w_keys_a_ev = wr_aligned & (wr_idx == `IMFB_IDX_KEYS_A_EV);
   assign w_keys_b_ev = wr_aligned & (wr_idx == `IMFB_IDX_KEYS_B_EV);
   assign w_tick_ev = wr_aligned & (wr_idx == `IMFB_IDX_TICK_EV);
   assign w_conv_ev = wr_aligned & (wr_idx == `IMFB_IDX_CONV_EV);
   assign wr_hit = w_pwm | w_match_en | w_wrap_en | w_keys_a_en | w_keys_b_en
                 | w_tick_en | w_conv_en | w_match_ev | w_wrap_ev | w_keys_a_ev
                 | w_keys_b_ev | w_tick_ev | w_conv_ev;

   logic r_pwm;
   logic r_match_en;
   logic r_wrap_en;
   logic r_keys_a_en;
   logic r_keys_b_en;
   logic r_tick_en;
   logic r_conv_en;
   logic r_match_ev;
   logic r_wrap_ev;
   logic r_keys_a_ev;
   logic r_keys_b_ev;
   logic r_tick_ev;
   logic r_conv_ev;
   assign r_pwm = rd_aligned & (rd_idx == `IMFB_IDX_PWM_SEL);
   assign r_match_en = rd_aligned & (rd_idx == `IMFB_IDX_MATCH_EN);
   assign r_wrap_en = rd_aligned & (rd_idx == `IMFB_IDX_WRAP_EN);
   assign r_keys_a_en = rd_aligned & (rd_idx == `IMFB_IDX_KEYS_A_EN);
   assign r_keys_b_en = rd_aligned & (rd_idx == `IMFB_IDX_KEYS_B_EN);
   assign r_tick_en = rd_aligned & (rd_idx == `IMFB_IDX_TICK_EN);
   assign r_conv_en = rd_aligned & (rd_idx == `IMFB_IDX_CONV_EN);
   assign r_match_ev = rd_aligned & (rd_idx == `IMFB_IDX_MATCH_EV);
   assign r_wrap_ev = rd_aligned & (rd_idx == `IMFB_IDX_WRAP_EV);
   assign r_keys_a_ev = rd_aligned & (rd_idx == `IMFB_IDX_KEYS_A_EV);
   assign r_keys_b_ev = rd_aligned & (rd_idx == `IMFB_IDX_KEYS_B_EV);
   assign r_tick_ev = rd_aligned & (rd_idx == `IMFB_IDX_TICK_EV);
   assign r_conv_ev = rd_aligned & (rd_idx == `IMFB_IDX_CONV_EV);
   assign rd_hit = r_pwm | r_match_en | r_wrap_en | r_keys_a_en | r_keys_b_en
                 | r_tick_en | r_conv_en | r_match_ev | r_wrap_ev | r_keys_a_ev
                 | r_keys_b_ev | r_tick_ev | r_conv_ev;

   logic [1:0] pwm_route_r;
   logic [1:0] match_allow_r;
   logic [1:0] wrap_allow_r;
   logic keys_a_allow_r;
   logic keys_b_allow_r;
   logic [3:0] tick_allow_r;
   logic [1:0] conv_allow_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pwm_route_r <= `IMFB_RST_2;
      end else if (wr_en && w_pwm) begin
         pwm_route_r <= wr_data[1:0];
      end
   end
   assign timer0_pwm_route = pwm_route_r[`IMFB_BIT_T0];
   assign timer1_pwm_route = pwm_route_r[`IMFB_BIT_T1];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         match_allow_r <= `IMFB_RST_2;
      end else if (wr_en && w_match_en) begin
         match_allow_r <= wr_data[1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         wrap_allow_r <= `IMFB_RST_2;
      end else if (wr_en && w_wrap_en) begin
         wrap_allow_r <= wr_data[1:0];
      end
   end

   // Key group enables, bit 0 only
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         keys_a_allow_r <= `IMFB_RST_1;
         keys_b_allow_r <= `IMFB_RST_1;
      end else begin
         if (wr_en && w_keys_a_en) begin
            keys_a_allow_r <= wr_data[`IMFB_BIT_KEYS];
         end
         if (wr_en && w_keys_b_en) begin
            keys_b_allow_r <= wr_data[`IMFB_BIT_KEYS];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         tick_allow_r <= `IMFB_RST_4;
      end else if (wr_en && w_tick_en) begin
         tick_allow_r <= wr_data;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         conv_allow_r <= `IMFB_RST_2;
      end else if (wr_en && w_conv_en) begin
         conv_allow_r <= wr_data[1:0];
      end
   end

   // Write-one clear strobes; a written zero leaves the flag alone
   logic [1:0] match_clr;
   logic [1:0] wrap_clr;
   logic keys_a_clr;
   logic keys_b_clr;
   logic [3:0] tick_clr;
   logic [1:0] conv_clr;
   assign match_clr = {2{wr_en & w_match_ev}} & wr_data[1:0];
   assign wrap_clr = {2{wr_en & w_wrap_ev}} & wr_data[1:0];
   assign keys_a_clr = wr_en & w_keys_a_ev & wr_data[`IMFB_BIT_KEYS];
   assign keys_b_clr = wr_en & w_keys_b_ev & wr_data[`IMFB_BIT_KEYS];
   assign tick_clr = {4{wr_en & w_tick_ev}} & wr_data;
   assign conv_clr = {2{wr_en & w_conv_ev}} & wr_data[1:0];

   logic [1:0] match_pending;
   logic [1:0] wrap_pending;
   logic keys_a_pending;
   logic keys_b_pending;
   logic [3:0] tick_pending;
   logic [1:0] conv_pending;

   imfb_event_word #(.W(2)) u_match (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(timer_match_event),
      .clr_in(match_clr),
      .flag(match_pending)
   );

   imfb_event_word #(.W(2)) u_wrap (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(timer_wrap_event),
      .clr_in(wrap_clr),
      .flag(wrap_pending)
   );

   imfb_event_word #(.W(1)) u_keys_a (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(keys_a_event),
      .clr_in(keys_a_clr),
      .flag(keys_a_pending)
   );

   imfb_event_word #(.W(1)) u_keys_b (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(keys_b_event),
      .clr_in(keys_b_clr),
      .flag(keys_b_pending)
   );

   imfb_event_word #(.W(4)) u_tick (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(tick_event),
      .clr_in(tick_clr),
      .flag(tick_pending)
   );

   imfb_event_word #(.W(2)) u_conv (
      .clock(clock),
      .sys_rst(sys_rst),
      .set_in(conv_event),
      .clr_in(conv_clr),
      .flag(conv_pending)
   );

   logic [3:0] word_pwm;
   logic [3:0] word_match_en;
   logic [3:0] word_wrap_en;
   logic [3:0] word_keys_a_en;
   logic [3:0] word_keys_b_en;
   logic [3:0] word_tick_en;
   logic [3:0] word_conv_en;
   logic [3:0] word_match_ev;
   logic [3:0] word_wrap_ev;
   logic [3:0] word_keys_a_ev;
   logic [3:0] word_keys_b_ev;
   logic [3:0] word_tick_ev;
   logic [3:0] word_conv_ev;
   assign word_pwm = {2'h0, pwm_route_r};
   assign word_match_en = {2'h0, match_allow_r};
   assign word_wrap_en = {2'h0, wrap_allow_r};
   assign word_keys_a_en = {3'h0, keys_a_allow_r};
   assign word_keys_b_en = {3'h0, keys_b_allow_r};
   assign word_tick_en = tick_allow_r;
   assign word_conv_en = {2'h0, conv_allow_r};
   assign word_match_ev = {2'h0, match_pending};
   assign word_wrap_ev = {2'h0, wrap_pending};
   assign word_keys_a_ev = {3'h0, keys_a_pending};
   assign word_keys_b_ev = {3'h0, keys_b_pending};
   assign word_tick_ev = tick_pending;
   assign word_conv_ev = {2'h0, conv_pending};

   assign rd_data = ({4{r_pwm}} & word_pwm)
                  | ({4{r_match_en}} & word_match_en)
                  | ({4{r_wrap_en}} & word_wrap_en)
                  | ({4{r_keys_a_en}} & word_keys_a_en)
                  | ({4{r_keys_b_en}} & word_keys_b_en)
                  | ({4{r_tick_en}} & word_tick_en)
                  | ({4{r_conv_en}} & word_conv_en)
                  | ({4{r_match_ev}} & word_match_ev)
                  | ({4{r_wrap_ev}} & word_wrap_ev)
                  | ({4{r_keys_a_ev}} & word_keys_a_ev)
                  | ({4{r_keys_b_ev}} & word_keys_b_ev)
                  | ({4{r_tick_ev}} & word_tick_ev)
                  | ({4{r_conv_ev}} & word_conv_ev);

   logic [13:0] live_src;
   logic irq_req_nxt;
   logic irq_req_r;
   assign live_src = {match_pending & match_allow_r,
                      wrap_pending & wrap_allow_r,
                      keys_a_pending & keys_a_allow_r,
                      keys_b_pending & keys_b_allow_r,
                      tick_pending & tick_allow_r,
                      conv_pending & conv_allow_r};
   assign irq_req_nxt = |live_src;

   // Registered so the core sees a glitch-free level
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         irq_req_r <= 1'b0;
      end else begin
         irq_req_r <= irq_req_nxt;
      end
   end
   assign irq_req = irq_req_r;
endmodule

// ---- tb/imfb_irq_bank_assertions.sv ----
// Protocol and interrupt checks for the mask and flag bank
`timescale 1ns/1ps
module imfb_irq_bank_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] timer_match_event,
   input wire logic [1:0] timer_wrap_event,
   input wire logic keys_a_event,
   input wire logic keys_b_event,
   input wire logic [3:0] tick_event,
   input wire logic [1:0] conv_event,
   input wire logic timer0_pwm_route,
   input wire logic timer1_pwm_route,
   input wire logic irq_req
);
   wire any_ev = |{timer_match_event, timer_wrap_event, keys_a_event, keys_b_event,
      tick_event, conv_event};
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   rd_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped early");
   ar_ready_a:
      assert property (s_axi_arready == !s_axi_rvalid) else $error("arready not inverse of rvalid");
   rd_latency_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
   wr_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped early");
   wr_block_a:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("new write taken while answering");
   rdata_zero_a:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0) else $error("upper bits set");
   irq_rise_a:
      assert property ($rose(irq_req) |-> $past(any_ev, 2) || $past(s_axi_bvalid))
      else $error("request rose without cause");
   irq_fall_a:
      assert property ($fell(irq_req) |-> $past(s_axi_bvalid) || $past(sys_rst))
      else $error("request fell without a write");
   route_write_a:
      assert property ($changed({timer1_pwm_route, timer0_pwm_route}) |-> s_axi_bvalid
         || $past(sys_rst)) else $error("route changed without a write");
   reset_clear_a:
      assert property ($fell(sys_rst) |-> !irq_req && !timer0_pwm_route && !timer1_pwm_route)
      else $error("outputs not cleared by reset");
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
   cover property ($rose(irq_req));
endmodule
bind imfb_irq_bank imfb_irq_bank_chk u_chk (.clock(clock), .sys_rst(sys_rst),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .timer_match_event(timer_match_event),
   .timer_wrap_event(timer_wrap_event), .keys_a_event(keys_a_event),
   .keys_b_event(keys_b_event), .tick_event(tick_event), .conv_event(conv_event),
   .timer0_pwm_route(timer0_pwm_route), .timer1_pwm_route(timer1_pwm_route),
   .irq_req(irq_req));

// ---- tb/imfb_irq_bank_tb.sv ----
// Self-checking bench for the mask and flag bank
`timescale 1ns/1ps
`include "imfb_regs.svh"
`define TB_CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module imfb_irq_bank_tb;
   logic clock = 0;
   logic sys_rst = 1;
   logic [`IMFB_ADDR_W-1:0] awaddr = '0;
   logic [`IMFB_ADDR_W-1:0] araddr = '0;
   logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'h0;
   logic [3:0] ev [6];
   logic [3:0] exp_v [13];
   wire awready, wready, bvalid, arready, rvalid, r0, r1, irq;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   int fail_count = 0, checked = 0, seed = 76584, to = 0;
   // Enables at 1..6, flags at 7..12, same source order
   logic [15:0] idx [13] = '{16'hFFD8, 16'hFFE0, 16'hFFE1, 16'hFFE3, 16'hFFE4, 16'hFFE5,
      16'hFFE7, 16'hFFF0, 16'hFFF1, 16'hFFF3, 16'hFFF4, 16'hFFF5, 16'hFFF7};
   logic [3:0] mask [13] = '{4'h3, 4'h3, 4'h3, 4'h1, 4'h1, 4'hF, 4'h3,
      4'h3, 4'h3, 4'h1, 4'h1, 4'hF, 4'h3};
   logic [15:0] unm [4] = '{16'hFFE2, 16'hFFE6, 16'hFFF6, 16'h0000};
   always #25 clock = ~clock;
   imfb_irq_bank dut (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_match_event(ev[0][1:0]), .timer_wrap_event(ev[1][1:0]), .keys_a_event(ev[2][0]),
      .keys_b_event(ev[3][0]), .tick_event(ev[4]), .conv_event(ev[5][1:0]),
      .timer0_pwm_route(r0), .timer1_pwm_route(r1), .irq_req(irq));
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic tmo();
      to++;
      if (to > 100) begin
         fail_count++;
         $display("ERROR handshake exp 1 got 0");
         summarize();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [3:0] d, input logic s,
      input logic [1:0] er);
      to = 0;
      @(posedge clock);
      awaddr <= {a, 2'b00};
      wdata <= {28'h0, d};
      wstrb <= {3'h0, s};
      awv <= 1;
      wv <= 1;
      bready <= 1;
      // Address and data may be taken on different edges
      do begin
         @(posedge clock);
         tmo();
         if (awv && awready) awv <= 0;
         if (wv && wready) wv <= 0;
      end while ((awv && !awready) || (wv && !wready));
      do begin
         @(posedge clock);
         tmo();
      end while (!bvalid);
      bready <= 0;
      `TB_CHK("bresp", er, bresp)
   endtask
   task automatic rd(input logic [15:0] a, input logic [3:0] e, input logic [1:0] er);
      to = 0;
      @(posedge clock);
      araddr <= {a, 2'b00};
      arv <= 1;
      rready <= 1;
      do begin
         @(posedge clock);
         tmo();
      end while (!arready);
      arv <= 0;
      do begin
         @(posedge clock);
         tmo();
      end while (!rvalid);
      rready <= 0;
      `TB_CHK("rdata", {28'h0, e}, rdata)
      `TB_CHK("rresp", er, rresp)
   endtask
   function automatic logic exp_irq();
      logic e = 0;
      for (int k = 0; k < 6; k++) e |= |(exp_v[1 + k] & exp_v[7 + k]);
      return e;
   endfunction
   task automatic settle();
      @(posedge clock);
      #1;
      `TB_CHK("irq_req", exp_irq(), irq)
      `TB_CHK("pwm_route", exp_v[0][1:0], {r1, r0})
   endtask
   task automatic pulse(input int k, input logic [3:0] b);
      @(posedge clock);
      ev[k] <= b & mask[7 + k];
      @(posedge clock);
      ev[k] <= 4'h0;
      exp_v[7 + k] |= b & mask[7 + k];
   endtask
   // Enables store masked data, flags clear where ones are written
   task automatic acc(input int i, input logic [3:0] d);
      wr(idx[i], d, 1'b1, 2'h0);
      if (i < 7) exp_v[i] = d & mask[i];
      else exp_v[i] &= ~(d & mask[i]);
      settle();
   endtask
   initial begin
      int i;
      logic [3:0] d;
      foreach (ev[k]) ev[k] = 4'h0;
      foreach (exp_v[k]) exp_v[k] = 4'h0;
      repeat (2) @(posedge clock);
      sys_rst <= 0;
      for (int n = 0; n < 13; n++) rd(idx[n], 4'h0, 2'h0);
      settle();
      $display("test reset done");
      acc(0, 4'hF);
      acc(0, 4'h2);
      for (int k = 0; k < 6; k++) begin
         acc(1 + k, 4'hF);
         pulse(k, 4'hF);
         settle();
         rd(idx[7 + k], mask[7 + k], 2'h0);
         acc(1 + k, 4'h0);
         acc(7 + k, 4'h0);
         acc(7 + k, 4'hF);
         rd(idx[7 + k], 4'h0, 2'h0);
      end
      $display("test sources done");
      pulse(4, 4'hF);
      // Event landing with the clear keeps those flags
      fork
         wr(idx[11], 4'hF, 1'b1, 2'h0);
         begin
            repeat (2) @(posedge clock);
            ev[4] <= 4'h5;
            @(posedge clock);
            ev[4] <= 4'h0;
         end
      join
      exp_v[11] = 4'h5;
      rd(idx[11], 4'h5, 2'h0);
      wr(idx[0], 4'h1, 1'b0, 2'h0);
      rd(idx[0], exp_v[0], 2'h0);
      foreach (unm[k]) begin
         wr(unm[k], 4'hF, 1'b1, 2'h2);
         rd(unm[k], 4'h0, 2'h2);
      end
      $display("test corners done");
      for (int n = 0; n < 80; n++) begin
         i = $unsigned($random(seed)) % 13;
         d = $random(seed);
         case ($unsigned($random(seed)) % 3)
            0: pulse(i % 6, d);
            1: acc(i, d);
            default: rd(idx[i], exp_v[i], 2'h0);
         endcase
         settle();
      end
      $display("test random done");
      summarize();
   end
endmodule
